// ===== core/mc_mapper_regs.vh
// Constants of the multi-configuration process image mapper.
`ifndef MC_MAPPER_REGS_VH
`define MC_MAPPER_REGS_VH
`define ASSIGN_REG_COUNT    6'h20
`define ASSIGN_FIELD_W      2
`define ASSIGN_NORMAL       2'h0
`define ASSIGN_DISABLED     2'h2
`define CFG_BUF_BYTES       8'h40
`define CFG_BYTES_PER_TERM  8'h02
`define MAX_TERMS           8'h80
`define IND_HOLD_CYCLES     8'h04
`define FIFO_DEPTH          16
`endif

// ===== core/word_fifo.v
// Synchronous FIFO with valid and ready on both sides.
module word_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire             mclk,
  input  wire             rst,
  input  wire             inValid,
  output wire             inReady,
  input  wire [WIDTH-1:0] inData,
  output wire             outValid,
  input  wire             outReady,
  output wire [WIDTH-1:0] outData
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wrPtr;
  reg [AW-1:0]    rdPtr;
  reg [AW:0]      count;
  wire            doWr;
  wire            doRd;

  assign inReady  = (count != DEPTH[AW:0]);
  assign outValid = (count != {(AW+1){1'b0}});
  assign outData  = mem[rdPtr];
  assign doWr     = inValid & inReady;
  assign doRd     = outValid & outReady;

  always @(posedge mclk) begin
    if (doWr) begin
      mem[wrPtr] <= inData;
    end
  end

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      wrPtr <= {AW{1'b0}};
      rdPtr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end else begin
      if (doWr) begin
        wrPtr <= (wrPtr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wrPtr + 1'b1;
      end
      if (doRd) begin
        rdPtr <= (rdPtr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rdPtr + 1'b1;
      end
      if (doWr && !doRd) begin
        count <= count + 1'b1;
      end else if (doRd && !doWr) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule // word_fifo

// ===== core/multi_config_process_image_mapper.v
// Multi-configuration process image mapper: checks the configuration and masks disabled slots.
// Function
// - Compare configuration against detected terminals.
// - Complex terminals first, then digital, plug order.
// - Outputs in telegram, inputs in its response.
// - Image layout fixed whatever terminals are present.
// - Unresolved: static diag set, no cycles, dark.
// - After assignment: recheck, clear diag, run cycles.
// - Presence assignment kept in non-volatile storage.
// - Two-bit presence fields, eight per register.
// - Configuration buffer 64 bytes, two per terminal.
`include "mc_mapper_regs.vh"
module multi_config_process_image_mapper #(
  parameter TERMS    = 128,
  parameter TW       = 7,
  parameter DW       = 8,
  parameter CFG_MAX  = 64
) (
  input  wire          mclk,
  input  wire          rst,
  input  wire          cfgStart,
  input  wire          cfgByteValid,
  input  wire [7:0]    cfgByte,
  input  wire          cfgEnd,
  input  wire [TW:0]   detectedCount,
  input  wire          assignWrite,
  input  wire [4:0]    assignReg,
  input  wire [15:0]   assignData,
  input  wire          nvValid,
  input  wire [4:0]    nvReg,
  input  wire [15:0]   nvData,
  output reg           nvWrite,
  output reg  [4:0]    nvWriteReg,
  output reg  [15:0]   nvWriteData,
  input  wire          exchangeStart,
  input  wire          outSlotValid,
  input  wire [TW-1:0] outSlot,
  input  wire [DW-1:0] outSlotData,
  output wire          outSlotReady,
  output wire          termOutValid,
  input  wire          termOutReady,
  output wire [DW-1:0] termOutData,
  output wire [TW-1:0] termOutIndex,
  input  wire          termInValid,
  input  wire [TW-1:0] termInSlot,
  input  wire [DW-1:0] termInData,
  output reg           respValid,
  output reg  [TW-1:0] respSlot,
  output reg  [DW-1:0] respData,
  output reg           staticDiag,
  output reg           termCycleReq,
  output reg           cycleIndicator,
  output reg           cfgOverflow,
  output reg           cfgMismatch
);
  localparam ST_IDLE  = 4'b0001;
  localparam ST_CFG   = 4'b0010;
  localparam ST_HOLD  = 4'b0100;
  localparam ST_RUN   = 4'b1000;

  reg [3:0]        state;
  reg [1:0]        presence [0:TERMS-1];
  reg [7:0]        cfgCount;
  reg [TW:0]       enabledCount;
  reg [7:0]        indTimer;
  reg              assignSeen;
  reg              cfgDone;
  reg [TW:0]       cntAcc;
  // Each process owns its loop variable so no variable has two drivers.
  integer          i;
  integer          j;

  wire             assignInRange;
  wire             nvInRange;

  wire             cfgMatch;
  wire             fifoInValid;
  wire             fifoInReady;
  wire [TW+DW-1:0] fifoOutWord;

  // Number of terminals not set to disabled; counts every entry of the presence table.
  always @* begin
    cntAcc = {(TW+1){1'b0}};
    for (j = 0; j < TERMS; j = j + 1) begin
      if (presence[j] != `ASSIGN_DISABLED) begin
        cntAcc = cntAcc + 1'b1;
      end
    end
  end

  assign cfgMatch = (enabledCount == detectedCount);

  // Registers beyond the table are stored but ignored here, so hardware never wraps them.
  assign assignInRange = ({3'h0, assignReg} < (TERMS / 8));
  assign nvInRange     = ({3'h0, nvReg} < (TERMS / 8));

  // Presence table, loaded from non-volatile storage or written by the master.
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      for (i = 0; i < TERMS; i = i + 1) begin
        presence[i] <= `ASSIGN_NORMAL;
      end
      nvWrite     <= 1'b0;
      nvWriteReg  <= 5'h00;
      nvWriteData <= 16'h0000;
      assignSeen  <= 1'b0;
    end else begin
      nvWrite <= 1'b0;
      if (assignWrite) begin
        for (i = 0; i < 8; i = i + 1) begin
          if (assignInRange) begin
            presence[{assignReg, 3'h0} + i] <= assignData[2*i +: 2];
          end
        end
        nvWrite     <= 1'b1;
        nvWriteReg  <= assignReg;
        nvWriteData <= assignData;
        assignSeen  <= 1'b1;
      end else if (nvValid) begin
        for (i = 0; i < 8; i = i + 1) begin
          if (nvInRange) begin
            presence[{nvReg, 3'h0} + i] <= nvData[2*i +: 2];
          end
        end
      end else if (state == ST_RUN) begin
        assignSeen <= 1'b0;
      end
    end
  end

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      enabledCount <= {(TW+1){1'b0}};
    end else begin
      enabledCount <= cntAcc;
    end
  end

  // Configuration reception and check; the buffer holds two bytes per terminal.
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      state          <= ST_IDLE;
      cfgCount       <= 8'h00;
      cfgOverflow    <= 1'b0;
      cfgMismatch    <= 1'b0;
      cfgDone        <= 1'b0;
      staticDiag     <= 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (cfgStart) begin
            state       <= ST_CFG;
            cfgCount    <= 8'h00;
            cfgOverflow <= 1'b0;
          end
        end
        ST_CFG: begin
          if (cfgByteValid) begin
            if (cfgCount == CFG_MAX[7:0]) begin
              cfgOverflow <= 1'b1;
            end else begin
              cfgCount <= cfgCount + 1'b1;
            end
          end
          if (cfgEnd) begin
            if (cfgMatch && !cfgOverflow) begin
              state       <= ST_RUN;
              staticDiag  <= 1'b0;
              cfgMismatch <= 1'b0;
            end else begin
              state       <= ST_HOLD;
              staticDiag  <= 1'b1;
              cfgMismatch <= 1'b1;
            end
          end
        end
        ST_HOLD: begin
          // Re-check only after a fresh assignment so a stale table cannot release it.
          if (assignSeen && cfgMatch && !cfgOverflow) begin
            state       <= ST_RUN;
            staticDiag  <= 1'b0;
            cfgMismatch <= 1'b0;
          end else if (cfgStart) begin
            state    <= ST_CFG;
            cfgCount <= 8'h00;
            cfgOverflow <= 1'b0;
          end
        end
        ST_RUN: begin
          if (cfgStart) begin
            state    <= ST_CFG;
            cfgCount <= 8'h00;
            cfgOverflow <= 1'b0;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Terminal bus cycles run only in ST_RUN; the indicator lights during each cycle.
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      termCycleReq   <= 1'b0;
      cycleIndicator <= 1'b0;
      indTimer       <= 8'h00;
    end else begin
      termCycleReq <= (state == ST_RUN) && exchangeStart;
      if (state != ST_RUN) begin
        cycleIndicator <= 1'b0;
        indTimer       <= 8'h00;
      end else if (exchangeStart) begin
        cycleIndicator <= 1'b1;
        indTimer       <= `IND_HOLD_CYCLES;
      end else if (indTimer != 8'h00) begin
        indTimer <= indTimer - 1'b1;
      end else begin
        cycleIndicator <= 1'b0;
      end
    end
  end

  // Outputs to disabled slots, and any outside ST_RUN, are discarded; enabled ones queue toward the terminals.
  assign fifoInValid  = outSlotValid && (state == ST_RUN)
                        && (presence[outSlot] != `ASSIGN_DISABLED);
  assign outSlotReady = fifoInReady || (presence[outSlot] == `ASSIGN_DISABLED)
                        || (state != ST_RUN);

  word_fifo #(
    .WIDTH (TW + DW),
    .DEPTH (`FIFO_DEPTH),
    .AW    (4)
  ) outFifo (
    .mclk     (mclk),
    .rst      (rst),
    .inValid  (fifoInValid),
    .inReady  (fifoInReady),
    .inData   ({outSlot, outSlotData}),
    .outValid (termOutValid),
    .outReady (termOutReady),
    .outData  (fifoOutWord)
  );

  // Slot index is kept fixed so the image layout never shifts.
  assign termOutIndex = fifoOutWord[TW+DW-1:DW];
  assign termOutData  = fifoOutWord[DW-1:0];

  // Response inputs in fixed slots; disabled slots read zero.
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      respValid <= 1'b0;
      respSlot  <= {TW{1'b0}};
      respData  <= {DW{1'b0}};
    end else begin
      respValid <= termInValid && (state == ST_RUN);
      respSlot  <= termInSlot;
      if (presence[termInSlot] == `ASSIGN_DISABLED) begin
        respData <= {DW{1'b0}};
      end else begin
        respData <= termInData;
      end
    end
  end
endmodule // multi_config_process_image_mapper

// ===== tb/mapper_chk.sv
// Port checker for the process image mapper.
module mapper_chk #(parameter TW = 7) (
  input wire          mclk,
  input wire          rst,
  input wire          cfgEnd,
  input wire          cfgOverflow,
  input wire          assignWrite,
  input wire [4:0]    assignReg,
  input wire [15:0]   assignData,
  input wire          nvWrite,
  input wire [4:0]    nvWriteReg,
  input wire [15:0]   nvWriteData,
  input wire          exchangeStart,
  input wire          termCycleReq,
  input wire          cycleIndicator,
  input wire          staticDiag,
  input wire          termInValid,
  input wire [TW-1:0] termInSlot,
  input wire          respValid,
  input wire [TW-1:0] respSlot
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  chk_store_follows: assert property (assignWrite |=> nvWrite
    && nvWriteReg == $past(assignReg) && nvWriteData == $past(assignData)) else $error("no store");
  chk_store_cause: assert property (nvWrite |-> $past(assignWrite))
    else $error("stray store");
  chk_resp_next: assert property (termInValid |=> respValid && respSlot == $past(termInSlot))
    else $error("no response");
  chk_resp_cause: assert property (respValid |-> $past(termInValid))
    else $error("stray response");
  chk_hold_quiet: assert property (staticDiag |-> !termCycleReq)
    else $error("cycle in hold");
  chk_cycle_cause: assert property (termCycleReq |-> $past(exchangeStart && !staticDiag))
    else $error("stray cycle");
  chk_ind_lit: assert property (termCycleReq |-> cycleIndicator [*5])
    else $error("indicator short");
  chk_ind_cause: assert property ($rose(cycleIndicator) |-> termCycleReq)
    else $error("indicator lit");
  chk_overflow_hold: assert property (cfgOverflow && cfgEnd |=> staticDiag)
    else $error("overflow ran");
  cover property (termCycleReq);
  cover property ($fell(staticDiag));
  cover property (cfgOverflow);
endmodule // mapper_chk

bind multi_config_process_image_mapper mapper_chk #(.TW(TW)) u_chk (.mclk, .rst, .cfgEnd,
  .cfgOverflow, .assignWrite, .assignReg, .assignData, .nvWrite, .nvWriteReg, .nvWriteData,
  .exchangeStart, .termCycleReq, .cycleIndicator, .staticDiag, .termInValid, .termInSlot,
  .respValid, .respSlot);

// ===== tb/dp_master_model.sv
// Fieldbus master model: configuration, presence writes and telegrams.
module dp_master_model (
  input  wire         mclk,
  input  wire         outSlotReady,
  output logic        cfgStart = 0,
  output logic        cfgByteValid = 0,
  output logic [7:0]  cfgByte = 8'h00,
  output logic        cfgEnd = 0,
  output logic        assignWrite = 0,
  output logic [4:0]  assignReg = 5'h00,
  output logic [15:0] assignData = 16'h0000,
  output logic        exchangeStart = 0,
  output logic        outSlotValid = 0,
  output logic [6:0]  outSlot = 7'h00,
  output logic [7:0]  outSlotData = 8'h00
);
  timeunit 1ns;
  timeprecision 1ns;
  task automatic tick();
    @(posedge mclk);
    #2;
  endtask
  // The caller picks the byte count; the bench sends 4 bytes, and 65 to force an overflow.
  task automatic send_cfg(input int n);
    cfgStart = 1;
    tick();
    cfgStart = 0;
    for (int i = 0; i < n; i++) begin
      cfgByteValid = 1;
      cfgByte = i[7:0];
      tick();
    end
    cfgByteValid = 0;
    cfgByte = ~cfgByte;
    cfgEnd = 1;
    tick();
    cfgEnd = 0;
  endtask
  task automatic write_assign(input logic [4:0] r, input logic [15:0] d);
    assignWrite = 1;
    assignReg = r;
    assignData = d;
    tick();
    assignWrite = 0;
    assignData = ~d;
  endtask
  task automatic exchange();
    exchangeStart = 1;
    tick();
    exchangeStart = 0;
  endtask
  // Ready is combinational, so it is sampled mid-cycle where it has settled.
  task automatic put_out(input logic [6:0] s, input logic [7:0] d, input int tries,
                         output bit ok);
    outSlotValid = 1;
    outSlot = s;
    outSlotData = d;
    ok = 0;
    for (int k = 0; k < tries && !ok; k++) begin
      @(negedge mclk);
      ok = outSlotReady;
      tick();
    end
    outSlotValid = 0;
    outSlotData = ~d;
    tick();
  endtask
endmodule // dp_master_model

// ===== tb/tb_top.sv
// Self-checking bench for the process image mapper.
`include "mc_mapper_regs.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic       mclk = 0, rst = 1, termOutReady = 0, termInValid = 0;
  logic [7:0] detectedCount = 8'h80, termInData = 8'h00;
  logic [6:0] termInSlot = 7'h00;
  logic       nvValid = 0;
  logic [4:0] nvReg = 5'h00;
  logic [15:0] nvData = 16'h0000;
  wire        cfgStart, cfgByteValid, cfgEnd, assignWrite, exchangeStart, outSlotValid;
  wire        nvWrite, outSlotReady, termOutValid, respValid, staticDiag, termCycleReq;
  wire        cycleIndicator, cfgOverflow, cfgMismatch;
  wire [4:0]  assignReg, nvWriteReg;
  wire [15:0] assignData, nvWriteData;
  wire [7:0]  cfgByte, outSlotData, termOutData, respData;
  wire [6:0]  outSlot, termOutIndex, respSlot;
  int         num_errors = 0, n_compared = 0, en = 128, acc, n;
  bit         ok;
  logic [23:0] rows[5] = '{24'h000080, 24'hAAAA78, 24'h00027F, 24'h00037E, 24'h000A7E};
  always #25 mclk = ~mclk;
  dp_master_model m (.mclk, .outSlotReady, .cfgStart, .cfgByteValid, .cfgByte, .cfgEnd,
    .assignWrite, .assignReg, .assignData, .exchangeStart, .outSlotValid, .outSlot, .outSlotData);
  multi_config_process_image_mapper DUT (.mclk, .rst, .cfgStart, .cfgByteValid, .cfgByte,
    .cfgEnd, .detectedCount, .assignWrite, .assignReg, .assignData, .nvValid,
    .nvReg, .nvData, .nvWrite, .nvWriteReg, .nvWriteData, .exchangeStart,
    .outSlotValid, .outSlot, .outSlotData, .outSlotReady, .termOutValid, .termOutReady,
    .termOutData, .termOutIndex, .termInValid, .termInSlot, .termInData, .respValid,
    .respSlot, .respData, .staticDiag, .termCycleReq, .cycleIndicator, .cfgOverflow,
    .cfgMismatch);
  task automatic tick();
    @(posedge mclk);
    #2;
  endtask
  task automatic cmp(string what, logic [15:0] exp, logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  function automatic int ndis(logic [15:0] d);
    ndis = 0;
    for (int i = 0; i < 8; i++) ndis += (d[2*i+:2] == `ASSIGN_DISABLED);
  endfunction
  task automatic term_in(logic [6:0] s, logic [7:0] exp);
    termInValid = 1;
    termInSlot = s;
    termInData = 8'h5A;
    tick();
    termInValid = 0;
    termInData = 8'hA5;
    cmp("respData", exp, respData);
    cmp("respValid", 16'h0001, respValid);
    cmp("respSlot", s, respSlot);
    tick();
  endtask
  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge mclk);
    #2 rst = 0;
    cmp("reset", 16'h0000, {nvWrite, respValid, staticDiag, termCycleReq, cycleIndicator});
    foreach (rows[i]) begin
      detectedCount = rows[i][7:0];
      m.send_cfg(4);
      tick();
      cmp("diag cfg", en != rows[i][7:0], staticDiag);
      m.write_assign(5'h00, rows[i][23:8]);
      en = 128 - ndis(rows[i][23:8]);
      repeat (4) tick();
      cmp("diag write", en != rows[i][7:0], staticDiag);
    end
    // Terminals 0 and 1 are now disabled and the block is exchanging.
    term_in(7'h00, 8'h00);
    term_in(7'h02, 8'h5A);
    m.exchange();
    cmp("cycle", 16'h0003, {termCycleReq, cycleIndicator});
    m.put_out(7'h00, 8'hFF, 1, ok);
    cmp("dropped ready", 16'h0001, ok);
    acc = 0;
    for (int i = 0; i < 20; i++) begin
      m.put_out(7'h02, i[7:0], 1, ok);
      acc += ok;
    end
    cmp("refused", 1, acc < 20);
    cmp("accepted", `FIFO_DEPTH, acc);
    n = 0;
    for (int k = 0; k < 100; k++) begin
      @(negedge mclk);
      if (termOutValid && termOutReady) begin
        cmp("termOutIndex", 16'h0002, termOutIndex);
        cmp("termOutData", n, termOutData);
        n++;
      end
      tick();
      termOutReady = k[0];
    end
    cmp("drained", acc, n);
    m.send_cfg(65);
    tick();
    cmp("overflow", 16'h0007, {cfgOverflow, staticDiag, cfgMismatch});
    m.exchange();
    cmp("no cycle", 16'h0000, {termCycleReq, cycleIndicator});
    // Mid-run reset clears the table; the stored copy must bring it back.
    rst = 1;
    tick();
    cmp("reset run", 16'h0000, {staticDiag, cfgOverflow, cfgMismatch, termOutValid});
    rst = 0;
    tick();
    nvValid = 1;
    nvData = 16'h000A;
    tick();
    nvValid = 0;
    repeat (2) tick();
    m.send_cfg(4);
    tick();
    cmp("restore", 16'h0000, {staticDiag, cfgMismatch});
    wrap_up();
  end
endmodule // tb_top
